// >>> common/pmp_pkg.sv
// package: register map, field positions, reset values and source types
// Operation
// - modulus mode borrows ramp generator as aux accumulator
// - output frequency equals rate times (word+A/B)/2^32
// - aux accumulator wraps at B, not 2^32
// - each wrap adds one LSB to phase
// - tuning word 0x04, B 0x05, A 0x06
// - modulus mode owns frequency above all sources
// - ramp generator cannot sweep phase/amplitude meanwhile
// - phase/amplitude from profiles; amplitude needs keying enable
// - ramp second; unswept parameters follow profiles
// - profiles third, supply all three independently
// - parallel port lowest, only unclaimed parameters
// - enables at 0x01[23:22]; profile beats parallel
// - keying ramp overrides all other amplitude sources
// - ramp phase uses 16 MSBs, amplitude 12
package pmp_pkg;
    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTL_ONE = 8'h00;  // control_function_reg_one
    localparam logic [7:0] ADDR_CTL_TWO = 8'h01;  // second control register
    localparam logic [7:0] ADDR_TUNE    = 8'h04;  // tuning_word
    localparam logic [7:0] ADDR_DEN     = 8'h05;  // modulus_denominator
    localparam logic [7:0] ADDR_NUM     = 8'h06;  // modulus_numerator
    localparam int         NUM_REGS     = 5;      // register entries held
    // entry indices in the register arrays
    localparam int         IDX_CTL_ONE  = 0;
    localparam int         IDX_CTL_TWO  = 1;
    localparam int         IDX_TUNE     = 2;
    localparam int         IDX_DEN      = 3;
    localparam int         IDX_NUM      = 4;
    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int         BIT_MOD_EN   = 0;      // ctl one: modulus mode enable
    localparam int         BIT_KEY_EN   = 8;      // ctl one: output_shift_keying enable
    localparam int         BIT_KEY_RAMP = 9;      // ctl one: keying ramp drives amplitude
    localparam int         BIT_PROF_EN  = 23;     // ctl two: profile enable
    localparam int         BIT_PAR_EN   = 22;     // ctl two: parallel port enable
    localparam int         BIT_RAMP_EN  = 19;     // ctl two: ramp generator enable
    localparam int         POS_RAMP_DST = 20;     // ctl two [21:20]: ramp destination
    localparam int         POS_PAR_DST  = 0;      // ctl two [1:0]: parallel destination
    // destination codes
    localparam logic [1:0] DST_FREQ     = 2'h0;
    localparam logic [1:0] DST_PHASE    = 2'h1;
    localparam logic [1:0] DST_AMP      = 2'h2;
    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [31:0] RST_REG     = 32'h0000_0000;
    localparam logic [11:0] ASF_FULL    = 12'hFFF;  // amplitude when unscaled
    localparam logic [15:0] POW_NONE    = 16'h0000; // phase when unclaimed
    localparam logic [31:0] MIN_DEN     = 32'h0000_0002;
    // frequency source
    typedef enum logic [2:0] {
        SRC_MOD, SRC_RAMP, SRC_PROF, SRC_PAR, SRC_REG
    } pmp_src_t;
endpackage : pmp_pkg

// >>> common/pmp_aux_if.sv
// interface: link between the top and the auxiliary accumulator
`timescale 1ns/10ps
interface pmp_aux_if;
    logic [31:0] num;    // increment A
    logic [31:0] den;    // wrap value B
    logic        run;    // accumulator active
    logic        carry;  // one LSB into phase this sample
    modport ctrl (output num, output den, output run, input carry);
    modport acc  (input num, input den, input run, output carry);
endinterface : pmp_aux_if

// >>> rtl/pmp_aux_acc.sv
// module: auxiliary accumulator with programmable wrap value
`timescale 1ns/10ps
module pmp_aux_acc
    import pmp_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_clk_en,
    pmp_aux_if.acc    aux
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic [31:0] acc_q;    // running remainder
    logic [31:0] acc_d;
    logic        carry_q;  // wrap flag
    logic        carry_d;
    logic [32:0] sum;      // wide sum, no overflow

    // next remainder and carry
    always_comb begin
        sum     = {1'b0, acc_q} + {1'b0, aux.num};
        acc_d   = acc_q;
        carry_d = 1'b0;
        if (!aux.run || aux.den < MIN_DEN) begin
            acc_d = RST_REG;                           // idle: restart from zero
        end else if (sum >= {1'b0, aux.den}) begin
            acc_d   = 32'(sum - {1'b0, aux.den});
            carry_d = 1'b1;
        end else begin
            acc_d = sum[31:0];
        end
    end

    // register stage
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            acc_q   <= RST_REG;
            carry_q <= 1'b0;
        end else if (i_clk_en) begin
            acc_q   <= acc_d;
            carry_q <= carry_d;
        end
    end

    assign aux.carry = carry_q;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    wrap_bound_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_clk_en && aux.run && aux.den >= MIN_DEN && acc_q < aux.den
        && aux.num < aux.den ##1 $stable(aux.den) |-> acc_q < aux.den)
        else $error("aux remainder reached wrap value");
    carry_sum_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_clk_en && aux.run && aux.den >= MIN_DEN
        |=> carry_q == (({1'b0, $past(acc_q)} + {1'b0, $past(aux.num)})
                        >= {1'b0, $past(aux.den)}))
        else $error("aux carry does not match sum against wrap");
endmodule : pmp_aux_acc

// >>> rtl/pmp_top.sv
// module: programmable modulus frequency path and source priority
`timescale 1ns/10ps
module pmp_top
    import pmp_pkg::*;
(
    input  wire logic        i_clock,          // synthesizer clock
    input  wire logic        i_rst,            // master reset
    input  wire logic        i_clk_en,         // freezes all state when low
    input  wire logic        i_reg_wr,         // register buffer write strobe
    input  wire logic        i_reg_rd,         // register read strobe
    input  wire logic [7:0]  i_reg_addr,       // register offset
    input  wire logic [31:0] i_reg_wdata,      // write data
    input  wire logic        i_io_update,      // buffer to active transfer
    input  wire logic [2:0]  i_profile_pins,   // profile_select_pins (async)
    input  wire logic [31:0] i_par_data,       // parallel port word (async)
    input  wire logic [31:0] i_ramp_value,     // ramp generator output
    input  wire logic [31:0] i_prof_tune,      // selected profile tuning word
    input  wire logic [15:0] i_prof_pow,       // selected profile phase offset
    input  wire logic [11:0] i_prof_asf,       // selected profile amplitude
    input  wire logic [11:0] i_key_amp,        // keying ramp amplitude
    output logic      [31:0] o_reg_rdata,      // read data
    output logic      [2:0]  o_profile_sel,    // synced profile select
    output logic      [31:0] o_phase,          // phase accumulator
    output logic      [31:0] o_tune,           // applied tuning word
    output logic      [15:0] o_pow,            // applied phase offset
    output logic      [11:0] o_asf,            // applied amplitude
    output pmp_src_t         o_freq_src,       // winning frequency source
    output logic             o_ramp_busy       // ramp held as aux accumulator
);
    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    logic [2:0]  pins_m_q;   // first stage, read only by second
    logic [2:0]  pins_q;     // usable profile select
    logic [31:0] par_m_q;    // first stage
    logic [31:0] par_q;      // usable parallel word
    logic [2:0]  pins_d;
    logic [31:0] par_d;

    // second stage takes first stage only
    always_comb begin
        pins_d = pins_m_q;
        par_d  = par_m_q;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pins_m_q <= 3'h0;
            pins_q   <= 3'h0;
            par_m_q  <= 32'h0000_0000;
            par_q    <= 32'h0000_0000;
        end else if (i_clk_en) begin
            pins_m_q <= i_profile_pins;
            pins_q   <= pins_d;
            par_m_q  <= i_par_data;
            par_q    <= par_d;
        end
    end

    // -------------------------------------------------------------------
    // registers: buffered writes, active copy on update
    // -------------------------------------------------------------------
    logic [31:0] buf_q [NUM_REGS];  // write buffers
    logic [31:0] buf_d [NUM_REGS];
    logic [31:0] act_q [NUM_REGS];  // active values
    logic [31:0] act_d [NUM_REGS];
    logic [31:0] rdata_d;
    int          wr_idx;            // decoded entry, -1 unmapped

    // address decode
    always_comb begin
        case (i_reg_addr)
            ADDR_CTL_ONE: wr_idx = IDX_CTL_ONE;
            ADDR_CTL_TWO: wr_idx = IDX_CTL_TWO;
            ADDR_TUNE:    wr_idx = IDX_TUNE;
            ADDR_DEN:     wr_idx = IDX_DEN;
            ADDR_NUM:     wr_idx = IDX_NUM;
            default:      wr_idx = -1;           // unmapped
        endcase
    end

    // per-entry buffer and transfer
    for (genvar e = 0; e < NUM_REGS; e++) begin : g_reg
        assign buf_d[e] = (i_reg_wr && wr_idx == e) ? i_reg_wdata : buf_q[e];
        assign act_d[e] = i_io_update ? buf_q[e] : act_q[e];
    end

    // read returns active value, zero when unmapped
    always_comb begin
        rdata_d = o_reg_rdata;
        if (i_reg_rd) begin
            rdata_d = (wr_idx < 0) ? 32'h0000_0000 : act_q[wr_idx];
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < NUM_REGS; k++) begin
                buf_q[k] <= RST_REG;
                act_q[k] <= RST_REG;
            end
            o_reg_rdata <= 32'h0000_0000;
        end else if (i_clk_en) begin
            buf_q       <= buf_d;
            act_q       <= act_d;
            o_reg_rdata <= rdata_d;
        end
    end

    // -------------------------------------------------------------------
    // decoded controls
    // -------------------------------------------------------------------
    logic       mod_on;    // modulus mode active
    logic       key_en;    // amplitude control enabled
    logic       key_ramp;  // keying ramp drives amplitude
    logic       prof_en;
    logic       par_en;
    logic       ramp_en;   // ramp free for sweeping
    logic [1:0] ramp_dst;
    logic [1:0] par_dst;

    assign mod_on   = act_q[IDX_CTL_ONE][BIT_MOD_EN];
    assign key_en   = act_q[IDX_CTL_ONE][BIT_KEY_EN];
    assign key_ramp = act_q[IDX_CTL_ONE][BIT_KEY_RAMP];
    assign prof_en  = act_q[IDX_CTL_TWO][BIT_PROF_EN];
    assign par_en   = act_q[IDX_CTL_TWO][BIT_PAR_EN];
    assign ramp_en  = act_q[IDX_CTL_TWO][BIT_RAMP_EN] && !mod_on;
    assign ramp_dst = act_q[IDX_CTL_TWO][POS_RAMP_DST +: 2];
    assign par_dst  = act_q[IDX_CTL_TWO][POS_PAR_DST +: 2];

    // -------------------------------------------------------------------
    // auxiliary accumulator (borrowed ramp generator)
    // -------------------------------------------------------------------
    pmp_aux_if aux ();
    assign aux.num = act_q[IDX_NUM];
    assign aux.den = act_q[IDX_DEN];
    assign aux.run = mod_on;

    pmp_aux_acc u_aux (
        .i_clock  (i_clock),
        .i_rst    (i_rst),
        .i_clk_en (i_clk_en),
        .aux      (aux.acc)
    );

    // -------------------------------------------------------------------
    // source priority and phase accumulator
    // -------------------------------------------------------------------
    logic [31:0] tune_d;
    logic [15:0] pow_d;
    logic [11:0] asf_d;
    logic [31:0] phase_d;
    pmp_src_t    src_d;

    always_comb begin
        // frequency: modulus, ramp, profile, parallel, register
        if (mod_on) begin
            src_d = SRC_MOD;
        end else if (ramp_en && ramp_dst == DST_FREQ) begin
            src_d = SRC_RAMP;
        end else if (prof_en) begin
            src_d = SRC_PROF;
        end else if (par_en && par_dst == DST_FREQ) begin
            src_d = SRC_PAR;
        end else begin
            src_d = SRC_REG;
        end
        case (src_d)
            SRC_MOD:  tune_d = act_q[IDX_TUNE];
            SRC_RAMP: tune_d = i_ramp_value;
            SRC_PROF: tune_d = i_prof_tune;
            SRC_PAR:  tune_d = par_q;
            default:  tune_d = act_q[IDX_TUNE];
        endcase
        // phase: ramp, profile, parallel
        if (ramp_en && ramp_dst == DST_PHASE) begin
            pow_d = i_ramp_value[31:16];
        end else if (prof_en) begin
            pow_d = i_prof_pow;
        end else if (par_en && par_dst == DST_PHASE) begin
            pow_d = par_q[15:0];
        end else begin
            pow_d = POW_NONE;
        end
        // amplitude: needs keying enable; keying ramp first
        if (!key_en) begin
            asf_d = ASF_FULL;
        end else if (key_ramp) begin
            asf_d = i_key_amp;
        end else if (ramp_en && ramp_dst == DST_AMP) begin
            asf_d = i_ramp_value[31:20];
        end else if (prof_en) begin
            asf_d = i_prof_asf;
        end else if (par_en && par_dst == DST_AMP) begin
            asf_d = par_q[11:0];
        end else begin
            asf_d = ASF_FULL;
        end
        // word plus fractional carry each sample
        phase_d = o_phase + o_tune + {31'h0000_0000, aux.carry};
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_phase       <= RST_REG;
            o_tune        <= RST_REG;
            o_pow         <= POW_NONE;
            o_asf         <= ASF_FULL;
            o_freq_src    <= SRC_REG;
            o_ramp_busy   <= 1'b0;
            o_profile_sel <= 3'h0;
        end else if (i_clk_en) begin
            o_phase       <= phase_d;
            o_tune        <= tune_d;
            o_pow         <= pow_d;
            o_asf         <= asf_d;
            o_freq_src    <= src_d;
            o_ramp_busy   <= mod_on;
            o_profile_sel <= pins_q;
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    phase_carry_a: assert property (
        i_clk_en |=> o_phase == $past(o_phase) + $past(o_tune) + {31'h0, $past(aux.carry)})
        else $error("phase step not word plus carry");
    mod_freq_a: assert property (
        i_clk_en && mod_on |=> o_freq_src == SRC_MOD && o_tune == $past(act_q[IDX_TUNE]))
        else $error("modulus mode lost frequency");
    ramp_held_a: assert property (
        i_clk_en && mod_on && key_en && !key_ramp && !prof_en && !par_en
        |=> o_ramp_busy && o_asf == ASF_FULL && o_pow == POW_NONE)
        else $error("ramp swept while held as accumulator");
    prof_phase_a: assert property (
        i_clk_en && mod_on && prof_en |=> o_pow == $past(i_prof_pow))
        else $error("profile phase not applied in modulus mode");
    ramp_freq_a: assert property (
        i_clk_en && ramp_en && ramp_dst == DST_FREQ && prof_en
        |=> o_tune == $past(i_ramp_value) && o_pow == $past(i_prof_pow))
        else $error("ramp frequency or profile phase wrong");
    prof_win_a: assert property (
        i_clk_en && !mod_on && !ramp_en && prof_en && par_en && par_dst == DST_FREQ
        |=> o_freq_src == SRC_PROF && o_tune == $past(i_prof_tune))
        else $error("parallel port beat profiles");
    par_last_a: assert property (
        i_clk_en && !mod_on && !ramp_en && !prof_en && par_en && par_dst == DST_FREQ
        |=> o_tune == $past(par_q))
        else $error("parallel word not applied");
    key_amp_a: assert property (
        i_clk_en && key_en && key_ramp |=> o_asf == $past(i_key_amp))
        else $error("keying ramp did not own amplitude");
    ramp_phase_a: assert property (
        i_clk_en && ramp_en && ramp_dst == DST_PHASE |=> o_pow == $past(i_ramp_value[31:16]))
        else $error("ramp phase not upper sixteen bits");
endmodule : pmp_top

// >>> verification/pmp_tb_top.sv
// testbench: register access, modulus carry and source priority checks
`timescale 1ns/10ps
module pmp_tb_top
    import pmp_pkg::*;
;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    localparam logic [31:0] TUNE_VAL = 32'h4CCC_CCCC;  // word for a 3/10 ratio
    logic           i_clock;          // 25 MHz clock
    logic           i_rst;            // master reset
    logic           i_clk_en;         // run enable
    logic           i_reg_wr;         // buffer write strobe
    logic           i_reg_rd;         // read strobe
    logic [7:0]     i_reg_addr;       // register offset
    logic [31:0]    i_reg_wdata;      // write data
    logic           i_io_update;      // buffer to active transfer
    logic [2:0]     i_profile_pins;   // profile_select_pins
    logic [31:0]    i_par_data;       // parallel port word
    logic [31:0]    i_ramp_value;     // ramp generator output
    logic [31:0]    i_prof_tune;      // profile tuning word
    logic [15:0]    i_prof_pow;       // profile phase offset
    logic [11:0]    i_prof_asf;       // profile amplitude
    logic [11:0]    i_key_amp;        // keying ramp amplitude
    logic [31:0]    o_reg_rdata;      // read data
    logic [2:0]     o_profile_sel;    // synced profile select
    logic [31:0]    o_phase;          // phase accumulator
    logic [31:0]    o_tune;           // applied tuning word
    logic [15:0]    o_pow;            // applied phase offset
    logic [11:0]    o_asf;            // applied amplitude
    pmp_src_t       o_freq_src;       // winning frequency source
    logic           o_ramp_busy;      // ramp held as aux accumulator
    int             error_cnt;        // mismatches seen
    int             samples_checked;  // comparisons made
    logic [31:0]    p_frz;            // phase seen while frozen

    pmp_top dut (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_io_update(i_io_update),
        .i_profile_pins(i_profile_pins), .i_par_data(i_par_data),
        .i_ramp_value(i_ramp_value), .i_prof_tune(i_prof_tune), .i_prof_pow(i_prof_pow),
        .i_prof_asf(i_prof_asf), .i_key_amp(i_key_amp), .o_reg_rdata(o_reg_rdata),
        .o_profile_sel(o_profile_sel), .o_phase(o_phase), .o_tune(o_tune),
        .o_pow(o_pow), .o_asf(o_asf), .o_freq_src(o_freq_src),
        .o_ramp_busy(o_ramp_busy));

    // clock generator, half period 20 ns
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    // ---------------------------------------------------------------
    // helper tasks
    // ---------------------------------------------------------------
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one buffer write, strobe held for one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_clock);
        i_reg_wr    <= 1'b0;
    endtask : wr

    // buffer to active transfer
    task automatic upd();
        @(posedge i_clock);
        i_io_update <= 1'b1;
        @(posedge i_clock);
        i_io_update <= 1'b0;
    endtask : upd

    // read of an active value, data one edge after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clock);
        i_reg_rd   <= 1'b0;
        #1;
        chk(o_reg_rdata, exp);
    endtask : rd

    // program both controls, then check every applied parameter
    task automatic row(input logic [31:0] c1, input logic [31:0] c2, input pmp_src_t src,
                       input logic [31:0] f, input logic [15:0] p, input logic [11:0] a);
        wr(ADDR_CTL_ONE, c1);
        wr(ADDR_CTL_TWO, c2);
        upd();
        repeat (6) @(posedge i_clock);
        #1;
        chk({29'h0, o_freq_src}, {29'h0, src});
        chk(o_tune, f);
        chk({16'h0, o_pow}, {16'h0, p});
        chk({20'h0, o_asf}, {20'h0, a});
        chk({31'h0, o_ramp_busy}, {31'h0, c1[BIT_MOD_EN]});
    endtask : row

    // phase advance over a window must hold exactly n wrap carries
    task automatic mod_run(input logic [31:0] a, input logic [31:0] b, input int win,
                           input int n);
        logic [31:0] p0;
        wr(ADDR_NUM, a);
        wr(ADDR_DEN, b);
        upd();
        repeat (8) @(posedge i_clock);
        #1;
        p0 = o_phase;
        repeat (win) @(posedge i_clock);
        #1;
        chk(o_phase - p0, TUNE_VAL * 32'(win) + 32'(n));
    endtask : mod_run

    // verdict and end of run
    task automatic final_report();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        i_rst <= 1'b1;
        i_clk_en <= 1'b1;
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
        i_reg_addr <= 8'h00;
        i_reg_wdata <= 32'h0;
        i_io_update <= 1'b0;
        i_profile_pins <= 3'h0;
        i_par_data <= 32'h5555_6677;
        i_ramp_value <= 32'h89AB_CDEF;
        i_prof_tune <= 32'h1111_2222;
        i_prof_pow <= 16'h3333;
        i_prof_asf <= 12'h444;
        i_key_amp <= 12'h0BC;
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        // registers: buffered until transfer, unmapped reads zero
        wr(ADDR_TUNE, TUNE_VAL);
        rd(ADDR_TUNE, 32'h0);
        wr(ADDR_DEN, 32'h5);
        wr(ADDR_NUM, 32'h4);
        upd();
        rd(ADDR_TUNE, TUNE_VAL);
        rd(ADDR_DEN, 32'h5);
        rd(ADDR_NUM, 32'h4);
        rd(8'h02, 32'h0);
        // profile pins reach the select after synchronising
        @(posedge i_clock);
        i_profile_pins <= 3'h5;
        repeat (4) @(posedge i_clock);
        #1;
        chk({29'h0, o_profile_sel}, 32'h5);
        // modulus mode owns frequency, ramp busy, phase from profile
        row(32'h001, 32'hD8_0000, SRC_MOD, TUNE_VAL, 16'h3333, 12'hFFF);
        row(32'h101, 32'h80_0000, SRC_MOD, TUNE_VAL, 16'h3333, 12'h444);
        // ramp aimed at amplitude stays idle while held
        row(32'h101, 32'h28_0000, SRC_MOD, TUNE_VAL, 16'h0000, 12'hFFF);
        // wrap carries for one numerator and denominator pair over two windows
        mod_run(32'h4, 32'h5, 5, 4);
        mod_run(32'h4, 32'h5, 10, 8);
        // low enable freezes the phase accumulator
        @(posedge i_clock);
        i_clk_en <= 1'b0;
        @(posedge i_clock);
        #1;
        p_frz = o_phase;
        repeat (3) @(posedge i_clock);
        #1;
        chk(o_phase, p_frz);
        @(posedge i_clock);
        i_clk_en <= 1'b1;
        mod_run(32'h2, 32'h3, 3, 2);
        mod_run(32'h1, 32'h1, 4, 0);
        // ramp, profile and parallel ranking with modulus off
        row(32'h000, 32'hC8_0000, SRC_RAMP, 32'h89AB_CDEF, 16'h3333, 12'hFFF);
        row(32'h000, 32'h98_0000, SRC_PROF, 32'h1111_2222, 16'h89AB, 12'hFFF);
        row(32'h100, 32'hA8_0000, SRC_PROF, 32'h1111_2222, 16'h3333, 12'h89A);
        row(32'h300, 32'hA8_0000, SRC_PROF, 32'h1111_2222, 16'h3333, 12'h0BC);
        row(32'h000, 32'hC0_0000, SRC_PROF, 32'h1111_2222, 16'h3333, 12'hFFF);
        row(32'h100, 32'h80_0000, SRC_PROF, 32'h1111_2222, 16'h3333, 12'h444);
        row(32'h100, 32'h40_0002, SRC_REG, TUNE_VAL, 16'h0000, 12'h677);
        row(32'h000, 32'h40_0001, SRC_REG, TUNE_VAL, 16'h6677, 12'hFFF);
        row(32'h000, 32'h40_0000, SRC_PAR, 32'h5555_6677, 16'h0000, 12'hFFF);
        final_report();
    end

    // watchdog, well beyond the expected run length
    initial begin
        #(40 * 20000);
        error_cnt++;
        final_report();
    end
endmodule : pmp_tb_top
